// *** core/ioc_regs.svh ***
`ifndef IOC_REGS_SVH
`define IOC_REGS_SVH
// ------------------------------------------------------------
// corrector register map on the link
// ------------------------------------------------------------
`define IOC_ADDR_PAGE_ONE 16'h4001
`define IOC_ADDR_PAGE_TWO 16'h4002
`define IOC_ADDR_PAGE_CHAN 16'h4003
`define IOC_ADDR_PAGE_FUNC 16'h4004
`define IOC_ADDR_CORR_CTRL 16'h6068
// ------------------------------------------------------------
// register values
// ------------------------------------------------------------
`define IOC_VAL_ZERO 8'h00
`define IOC_VAL_CHAN_B 8'h01
`define IOC_VAL_FUNC_OFFS 8'h61
`define IOC_VAL_FREEZE 8'hc2
`define IOC_VAL_BYPASS 8'h46
`define IOC_RST_BYTE 8'h00
// ------------------------------------------------------------
// host command registers
// ------------------------------------------------------------
`define IOC_HREG_CTRL 4'h0
`define IOC_HREG_STATUS 4'h1
`define IOC_CTRL_FREEZE_BIT 0
`define IOC_CTRL_BYPASS_BIT 1
`define IOC_CTRL_SINGLE_BIT 2
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define IOC_CLK_NS 50
`define IOC_SETTLE_NS 400000
`define IOC_BOOT_NS 100
`define IOC_SETTLE_CYC ((`IOC_SETTLE_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)
`define IOC_BOOT_CYC ((`IOC_BOOT_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)
`endif

// *** core/ioc_pkg.sv ***
`default_nettype none
package ioc_pkg;
	// corrector operating mode per channel
	typedef enum logic [1:0] {IOC_RUN, IOC_FREEZE, IOC_BYPASS} ioc_mode_t;
	// host sequencer states
	typedef enum logic [2:0] {
		IOC_H_BOOT, IOC_H_IDLE, IOC_H_QUIET, IOC_H_SETTLE, IOC_H_WRITE
	} ioc_hstate_t;
endpackage
`default_nettype wire

// *** core/ioc_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// register write link between host and corrector
interface ioc_link_if;
	logic wr;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic [1:0] idle;
	modport dev (input wr, input addr, input wdata, output idle);
	modport hst (output wr, output addr, output wdata, input idle);
endinterface
`default_nettype wire

// *** core/ioc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ioc_regs.svh"
module ioc_host import ioc_pkg::*; #(
	parameter int SETTLE_CYC = `IOC_SETTLE_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// software port
	input wire logic [3:0] sw_addr_i,
	input wire logic [7:0] sw_wdata_i,
	input wire logic sw_wr_i,
	input wire logic sw_rd_i,
	output logic [7:0] sw_rdata_o,
	// system controls
	output logic src_on_o,
	output logic chb_pwrdn_o,
	// link to corrector
	ioc_link_if.hst link
);
	localparam int BOOT_CYC = `IOC_BOOT_CYC;
	localparam int CW = $clog2(SETTLE_CYC + 1);
	generate
		if (SETTLE_CYC < 1) begin : g_chk
			$error("SETTLE_CYC must be at least one");
		end
	endgenerate
	// ------------------------------------------------------------
	// page and control write sequence
	// ------------------------------------------------------------
	function automatic logic [15:0] step_addr(input logic [2:0] s);
		unique case (s)
			3'h0: step_addr = `IOC_ADDR_PAGE_ONE;
			3'h1: step_addr = `IOC_ADDR_PAGE_TWO;
			3'h2: step_addr = `IOC_ADDR_PAGE_CHAN;
			3'h3: step_addr = `IOC_ADDR_PAGE_FUNC;
			3'h5: step_addr = `IOC_ADDR_PAGE_CHAN;
			default: step_addr = `IOC_ADDR_CORR_CTRL;
		endcase
	endfunction
	function automatic logic [7:0] step_data(input logic [2:0] s, input logic frz);
		unique case (s)
			3'h3: step_data = `IOC_VAL_FUNC_OFFS;
			3'h5: step_data = `IOC_VAL_CHAN_B;
			3'h4, 3'h6: step_data = frz ? `IOC_VAL_FREEZE : `IOC_VAL_BYPASS;
			default: step_data = `IOC_VAL_ZERO;
		endcase
	endfunction
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ioc_hstate_t st_r, st_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [2:0] step_r, step_nxt;
	logic frz_r, frz_nxt;
	logic single_r, single_nxt;
	logic src_r, src_nxt;
	logic wr_r, wr_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic [7:0] wdat_r, wdat_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic ctl_wr, go_frz, go_byp, busy;
	assign ctl_wr = sw_wr_i && (sw_addr_i == `IOC_HREG_CTRL);
	assign go_frz = ctl_wr && sw_wdata_i[`IOC_CTRL_FREEZE_BIT];
	assign go_byp = ctl_wr && sw_wdata_i[`IOC_CTRL_BYPASS_BIT];
	assign busy = (st_r != IOC_H_IDLE);
	// sequencer next state
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		step_nxt = step_r;
		frz_nxt = frz_r;
		single_nxt = single_r;
		src_nxt = src_r;
		wr_nxt = 1'b0;
		addr_nxt = addr_r;
		wdat_nxt = wdat_r;
		if (ctl_wr && !busy) begin
			single_nxt = sw_wdata_i[`IOC_CTRL_SINGLE_BIT];
		end
		unique case (st_r)
			IOC_H_BOOT: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r >= CW'(BOOT_CYC - 1)) begin
					st_nxt = IOC_H_IDLE;
				end
			end
			IOC_H_IDLE: begin
				step_nxt = 3'h0;
				cnt_nxt = '0;
				if (go_frz) begin
					frz_nxt = 1'b1;
					src_nxt = 1'b0;
					st_nxt = IOC_H_QUIET;
				end else if (go_byp) begin
					frz_nxt = 1'b0;
					st_nxt = IOC_H_WRITE;
				end
			end
			IOC_H_QUIET: begin
				// wait for the corrector to see an idle input
				if (link.idle[0] && (single_r || link.idle[1])) begin
					st_nxt = IOC_H_SETTLE;
				end
			end
			IOC_H_SETTLE: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r >= CW'(SETTLE_CYC - 1)) begin
					st_nxt = IOC_H_WRITE;
				end
			end
			IOC_H_WRITE: begin
				wr_nxt = 1'b1;
				addr_nxt = step_addr(step_r);
				wdat_nxt = step_data(step_r, frz_r);
				step_nxt = step_r + 3'h1;
				if (step_r == (single_r ? 3'h4 : 3'h6)) begin
					src_nxt = 1'b1;
					st_nxt = IOC_H_IDLE;
				end
			end
		endcase
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r <= IOC_H_BOOT;
			cnt_r <= '0;
			step_r <= 3'h0;
			frz_r <= 1'b0;
			single_r <= 1'b0;
			src_r <= 1'b1;
			wr_r <= 1'b0;
			addr_r <= 16'h0000;
			wdat_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			step_r <= step_nxt;
			frz_r <= frz_nxt;
			single_r <= single_nxt;
			src_r <= src_nxt;
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			wdat_r <= wdat_nxt;
		end
	end
	// ------------------------------------------------------------
	// software read port
	// ------------------------------------------------------------
	always_comb begin
		rdata_nxt = 8'h00;
		if (sw_rd_i && sw_addr_i == `IOC_HREG_CTRL) begin
			rdata_nxt = {5'h00, single_r, 2'h0};
		end else if (sw_rd_i && sw_addr_i == `IOC_HREG_STATUS) begin
			rdata_nxt = {4'h0, src_r, link.idle, busy};
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end
	assign sw_rdata_o = rdata_r;
	assign src_on_o = src_r;
	assign chb_pwrdn_o = single_r;
	assign link.wr = wr_r;
	assign link.addr = addr_r;
	assign link.wdata = wdat_r;
endmodule // ioc_host
`default_nettype wire

// *** core/ioc_corrector.sv ***
// Operation
// - per channel remove four-core offset mismatch
// - cancel dc and every fs/8 multiple
// - run continuously, tones treated as mismatch
// - bypass passes samples uncorrected
// - freeze holds and applies last estimate
// - host idles input, waits 0.4 ms
// - detect idle input channel
// - page writes select channel A page
// - writing 01h to page_channel_select selects B
// - C2h to offset_corrector_control freezes selected channel
// - 46h to offset_corrector_control bypasses selected channel
// - restore source after both frozen
// - single channel keeps A, B down
// - first write 100 ns after reset
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ioc_regs.svh"
module ioc_corrector import ioc_pkg::*; #(
	parameter int W = 14,
	parameter int SH = 10,
	parameter int BINS = 8,
	parameter int IDLE_THR = 8,
	parameter int IDLE_LEN = 256
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// interleaved core samples
	input wire logic smp_valid_i,
	input wire logic [W-1:0] smp_a_i,
	input wire logic [W-1:0] smp_b_i,
	// corrected output
	output logic out_valid_o,
	output logic [W-1:0] out_a_o,
	output logic [W-1:0] out_b_o,
	// link from host
	ioc_link_if.dev link
);
	localparam int AW = W + SH;
	localparam int BW = $clog2(BINS);
	localparam int IW = $clog2(IDLE_LEN + 1);
	generate
		if (W < 2 || SH < 1 || BINS < 4 || (BINS & (BINS - 1)) != 0 || IDLE_LEN < 1) begin : g_chk
			$error("corrector parameters out of range");
		end
	endgenerate
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic ioc_mode_t decode_mode(input logic [7:0] v);
		if (v == `IOC_VAL_FREEZE) begin
			decode_mode = IOC_FREEZE;
		end else if (v == `IOC_VAL_BYPASS) begin
			decode_mode = IOC_BYPASS;
		end else begin
			decode_mode = IOC_RUN;
		end
	endfunction
	function automatic logic [W-1:0] sat_sub(input logic [W-1:0] x, input logic [W-1:0] e);
		logic signed [W:0] d;
		d = $signed({x[W-1], x}) - $signed({e[W-1], e});
		if (d[W] != d[W-1]) begin
			sat_sub = d[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
		end else begin
			sat_sub = d[W-1:0];
		end
	endfunction
	function automatic logic is_quiet(input logic [W-1:0] x);
		logic [W-1:0] m;
		m = x[W-1] ? (~x + 1'b1) : x;
		is_quiet = (m <= W'(IDLE_THR));
	endfunction
	// ------------------------------------------------------------
	// page and control registers
	// ------------------------------------------------------------
	logic [7:0] pg1_r, pg1_nxt, pg2_r, pg2_nxt, pgch_r, pgch_nxt, pgfn_r, pgfn_nxt;
	logic [7:0] ctl_r [2];
	logic [7:0] ctl_nxt [2];
	logic page_ok;
	assign page_ok = (pg1_r == `IOC_VAL_ZERO) && (pg2_r == `IOC_VAL_ZERO)
		&& (pgfn_r == `IOC_VAL_FUNC_OFFS);
	// register write decode
	always_comb begin
		pg1_nxt = pg1_r;
		pg2_nxt = pg2_r;
		pgch_nxt = pgch_r;
		pgfn_nxt = pgfn_r;
		ctl_nxt = ctl_r;
		if (link.wr) begin
			unique case (link.addr)
				`IOC_ADDR_PAGE_ONE: pg1_nxt = link.wdata;
				`IOC_ADDR_PAGE_TWO: pg2_nxt = link.wdata;
				`IOC_ADDR_PAGE_CHAN: pgch_nxt = link.wdata;
				`IOC_ADDR_PAGE_FUNC: pgfn_nxt = link.wdata;
				`IOC_ADDR_CORR_CTRL: begin
					if (page_ok) begin
						ctl_nxt[pgch_r[0]] = link.wdata;
					end
				end
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pg1_r <= `IOC_RST_BYTE;
			pg2_r <= `IOC_RST_BYTE;
			pgch_r <= `IOC_RST_BYTE;
			pgfn_r <= `IOC_RST_BYTE;
			ctl_r[0] <= `IOC_RST_BYTE;
			ctl_r[1] <= `IOC_RST_BYTE;
		end else begin
			pg1_r <= pg1_nxt;
			pg2_r <= pg2_nxt;
			pgch_r <= pgch_nxt;
			pgfn_r <= pgfn_nxt;
			ctl_r <= ctl_nxt;
		end
	end
	// ------------------------------------------------------------
	// offset estimator and correction
	// ------------------------------------------------------------
	logic [AW-1:0] acc_r [2][BINS];
	logic [AW-1:0] acc_nxt [2][BINS];
	logic [BW-1:0] bin_r, bin_nxt;
	logic [IW-1:0] qcnt_r [2];
	logic [IW-1:0] qcnt_nxt [2];
	logic [W-1:0] ya_r, ya_nxt, yb_r, yb_nxt;
	logic ov_r, ov_nxt;
	logic [W-1:0] smp [2];
	ioc_mode_t mode [2];
	logic [W-1:0] est [2];
	logic [W-1:0] y [2];
	assign smp[0] = smp_a_i;
	assign smp[1] = smp_b_i;
	// estimate update, idle detect and output per channel
	always_comb begin
		acc_nxt = acc_r;
		qcnt_nxt = qcnt_r;
		bin_nxt = bin_r;
		ov_nxt = smp_valid_i;
		ya_nxt = ya_r;
		yb_nxt = yb_r;
		for (int c = 0; c < 2; c++) begin
			mode[c] = decode_mode(ctl_r[c]);
			est[c] = acc_r[c][bin_r][AW-1:SH];
			y[c] = (mode[c] == IOC_BYPASS) ? smp[c] : sat_sub(smp[c], est[c]);
			if (smp_valid_i) begin
				if (mode[c] == IOC_RUN) begin
					// leaky mean per phase bin: every fs/8 multiple cancels
					acc_nxt[c][bin_r] = acc_r[c][bin_r] + {{SH{smp[c][W-1]}}, smp[c]}
						- {{SH{acc_r[c][bin_r][AW-1]}}, acc_r[c][bin_r][AW-1:SH]};
				end
				if (!is_quiet(smp[c])) begin
					qcnt_nxt[c] = '0;
				end else if (qcnt_r[c] != IW'(IDLE_LEN)) begin
					qcnt_nxt[c] = qcnt_r[c] + 1'b1;
				end
			end
		end
		if (smp_valid_i) begin
			bin_nxt = bin_r + 1'b1;
			ya_nxt = y[0];
			yb_nxt = y[1];
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int c = 0; c < 2; c++) begin
				for (int b = 0; b < BINS; b++) begin
					acc_r[c][b] <= '0;
				end
				qcnt_r[c] <= '0;
			end
			bin_r <= '0;
			ov_r <= 1'b0;
			ya_r <= '0;
			yb_r <= '0;
		end else begin
			acc_r <= acc_nxt;
			qcnt_r <= qcnt_nxt;
			bin_r <= bin_nxt;
			ov_r <= ov_nxt;
			ya_r <= ya_nxt;
			yb_r <= yb_nxt;
		end
	end
	// outputs
	assign out_valid_o = ov_r;
	assign out_a_o = ya_r;
	assign out_b_o = yb_r;
	assign link.idle = {(qcnt_r[1] == IW'(IDLE_LEN)),
		(qcnt_r[0] == IW'(IDLE_LEN))};
endmodule // ioc_corrector
`default_nettype wire

// *** verification/ioc_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module ioc_properties (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// link signals
	input wire logic wr,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [1:0] idle
);
	// ------------------------------------------------------------
	// helper logic
	// ------------------------------------------------------------
	// cycles since reset release, saturating at three
	logic [1:0] boot_r;
	logic [1:0] boot_nxt;
	always_comb begin
		boot_nxt = (boot_r == 2'h3) ? boot_r : boot_r + 2'h1;
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			boot_r <= 2'h0;
		end else begin
			boot_r <= boot_nxt;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// ------------------------------------------------------------
	// link write order
	// ------------------------------------------------------------
	a_seq_start: assert property ($rose(wr) |-> addr == 16'h4001 && wdata == 8'h00)
		else $error("link burst does not open with the first page byte");
	a_burst_len: assert property ($rose(wr) |-> wr [*5])
		else $error("link burst shorter than five writes");
	a_func_page: assert property (wr && addr == 16'h4004
		|-> wdata == 8'h61 ##1 (wr && addr == 16'h6068))
		else $error("function page byte wrong or not followed by control write");
	a_chan_b_step: assert property (wr && addr == 16'h4003 && wdata == 8'h01
		|-> $past(addr) == 16'h6068 ##1 (wr && addr == 16'h6068))
		else $error("channel b page not between two control writes");
	a_ctrl_code: assert property (wr && addr == 16'h6068
		|-> wdata == 8'hc2 || wdata == 8'h46)
		else $error("control write carries an unknown code");
	a_cmd_repeat: assert property (wr && addr == 16'h6068 ##1 wr && addr == 16'h4003
		|=> wr && addr == 16'h6068 && wdata == $past(wdata, 2))
		else $error("second channel got a different command");
	a_freeze_idle: assert property (wr && addr == 16'h6068 && wdata == 8'hc2 |-> idle[0])
		else $error("freeze issued while channel a not idle");
	a_boot_quiet: assert property (wr |-> boot_r >= 2'h2)
		else $error("link write too soon after reset");
endmodule // ioc_properties
`default_nettype wire

// *** verification/test_interleave_offset_corrector.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ioc_regs.svh"
module test_interleave_offset_corrector;
	localparam int W = 14;
	localparam int SETTLE = 20;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [3:0] sw_addr_i = 4'h0;
	logic [7:0] sw_wdata_i = 8'h00;
	logic sw_wr_i = 1'b0;
	logic sw_rd_i = 1'b0;
	logic smp_valid_i = 1'b0;
	logic [W-1:0] smp_a_i = '0;
	logic [W-1:0] smp_b_i = '0;
	logic [7:0] sw_rdata_o;
	logic src_on_o, chb_pwrdn_o, out_valid_o;
	logic [W-1:0] out_a_o, out_b_o;
	int err_count = 0;
	int comparisons = 0;
	ioc_link_if link ();
	// ------------------------------------------------------------
	// both ends and the checker
	// ------------------------------------------------------------
	ioc_host #(.SETTLE_CYC(SETTLE)) u_ioc_host (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
		.sw_rdata_o(sw_rdata_o), .src_on_o(src_on_o), .chb_pwrdn_o(chb_pwrdn_o), .link(link.hst));
	ioc_corrector #(.IDLE_LEN(4)) u_ioc_corrector (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.smp_valid_i(smp_valid_i), .smp_a_i(smp_a_i), .smp_b_i(smp_b_i),
		.out_valid_o(out_valid_o), .out_a_o(out_a_o), .out_b_o(out_b_o), .link(link.dev));
	ioc_properties u_ioc_properties (.clk_i(clk_i), .arst_n_i(arst_n_i), .wr(link.wr),
		.addr(link.addr), .wdata(link.wdata), .idle(link.idle));
	// 20 mhz clock
	always #25 clk_i = ~clk_i;
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic chk_smp(string what, logic [W-1:0] exp, logic [W-1:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic sw_write(logic [3:0] a, logic [7:0] d);
		@(posedge clk_i);
		sw_addr_i <= a;
		sw_wdata_i <= d;
		sw_wr_i <= 1'b1;
		@(posedge clk_i);
		sw_wr_i <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic sw_read(logic [3:0] a, logic [7:0] exp, string what);
		@(posedge clk_i);
		sw_addr_i <= a;
		sw_rd_i <= 1'b1;
		@(posedge clk_i);
		sw_rd_i <= 1'b0;
		#1;
		chk_byte(what, exp, sw_rdata_o);
	endtask
	// one sample on both channels, b mirrored; returns output of the previous one
	task automatic smp_step(logic [W-1:0] x, output logic [W-1:0] ya, output logic [W-1:0] yb);
		@(posedge clk_i);
		smp_valid_i <= 1'b1;
		smp_a_i <= x;
		smp_b_i <= -x;
		#1;
		ya = out_a_o;
		yb = out_b_o;
	endtask
	function automatic logic [7:0] status_exp(logic src, logic [1:0] idl, logic busy);
		return {4'h0, src, idl, busy};
	endfunction
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		#(5000 * 50);
		err_count++;
		finish_test();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [W-1:0] ya, yb, pa, fa, fb, x;
		int n;
		void'($urandom(63));
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		sw_read(`IOC_HREG_STATUS, status_exp(1'b1, 2'b00, 1'b0), "status after reset");
		sw_read(`IOC_HREG_CTRL, 8'h00, "control after reset");
		$display("reset test done");
		// running corrector follows a steady large input
		for (int i = 0; i < 64; i++) begin
			smp_step(14'h0fa0, ya, yb);
			if (i == 1) chk_smp("first corrected a", 14'h0fa0, ya);
		end
		chk_byte("run adapts", 8'h01, {7'h0, ya != 14'h0fa0});
		chk_byte("output valid", 8'h01, {7'h0, out_valid_o});
		$display("run test done");
		// freeze sequence, with a bypass order refused while busy
		sw_write(`IOC_HREG_CTRL, 8'h01);
		@(posedge clk_i);
		#1;
		chk_byte("source off", 8'h00, {7'h0, src_on_o});
		sw_write(`IOC_HREG_CTRL, 8'h02);
		sw_read(`IOC_HREG_STATUS, status_exp(1'b0, 2'b00, 1'b1), "status busy");
		n = 0;
		while (src_on_o !== 1'b1 && n < 200) begin
			smp_step(14'($urandom_range(16)) - 14'h0008, ya, yb);
			n++;
		end
		chk_byte("settle wait", 8'h01, {7'h0, n > SETTLE + 7 && n < 200});
		chk_byte("source restored", 8'h01, {7'h0, src_on_o});
		for (int i = 0; i < 41; i++) begin
			smp_step(14'h0fa0, ya, yb);
			if (i == 8) begin
				fa = ya;
				fb = yb;
			end
			if (i > 8 && i % 8 == 0) begin
				chk_smp("frozen a", fa, ya);
				chk_smp("frozen b", fb, yb);
			end
		end
		chk_byte("not bypassed", 8'h01, {7'h0, ya !== 14'h0fa0});
		$display("freeze test done");
		// bypass passes samples untouched
		sw_write(`IOC_HREG_CTRL, 8'h02);
		repeat (12) smp_step(14'h0fa0, ya, yb);
		pa = 14'h0fa0;
		for (int i = 0; i < 32; i++) begin
			x = 14'($urandom);
			smp_step(x, ya, yb);
			chk_smp("bypass a", pa, ya);
			chk_smp("bypass b", -pa, yb);
			pa = x;
		end
		// a loud sample so the held input cannot look idle
		smp_step(14'h0fa0, ya, yb);
		chk_byte("source kept", 8'h01, {7'h0, src_on_o});
		$display("bypass test done");
		// single channel and register reads
		sw_write(`IOC_HREG_CTRL, 8'h04);
		@(posedge clk_i);
		#1;
		chk_byte("channel b down", 8'h01, {7'h0, chb_pwrdn_o});
		sw_read(`IOC_HREG_CTRL, 8'h04, "control single");
		sw_read(4'h9, 8'h00, "unmapped");
		sw_read(`IOC_HREG_STATUS, status_exp(1'b1, 2'b00, 1'b0), "status end");
		$display("single test done");
		finish_test();
	end
endmodule // test_interleave_offset_corrector
`default_nettype wire
